// ---- hw/fsc_config_update.sv ----
`timescale 1ns/100ps
`include "fsc_consts.svh"
// Summary of operation
// - Mode bit 4 selects normal (0) or triggered (1); resets to 0.
// - Mode bit 5 selects master (0) or slave (1); resets to 0.
// - Mode bit 7 enables subsampling when 1; resets to 0.
// - Mode bit 8 enables binning when 1; resets to 0.
// - Window writes accepted in standby, idle and running alike.
// - Window geometry at 256..351; two enable registers pick active windows.
// - After reset only window 0, full frame, is active.
// - Exposure and gain writes accepted in every state.
// - Black level changes when running may spoil several frames.
// - Sync code changes when running may spoil the current frame.
// - Test pattern changes when running may spoil one frame.
// - Frame parameters change only at frame boundaries.
// - Window switches blank one frame and send training patterns.
// - Subsampling and binning changes apply at next frame start.
// - Writes to 195 or 196 are a window switch; geometry is not.
// - Resizing the active window never blanks a frame.
// - Exposure lags one extra frame unless triggered master sync mode.
// - Gain applies next frame start; bit 13 delays one more frame.
// - A frozen group keeps its active values, ignoring new writes.
module fsc_config_update (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Register port from the serial control decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fsc_pkg::fsc_addr_t reg_addr,
  input wire fsc_pkg::fsc_word_t reg_wdata,
  output fsc_pkg::fsc_word_t reg_rdata,
  // Sequencer timing
  input wire logic frame_start,
  // Configuration towards the sequencer
  output logic seq_enable,
  output logic triggered_mode,
  output logic slave_mode,
  output logic subsample_en,
  output logic binning_en,
  output logic [31:0] window_enable,
  output logic [47:0] exposure_active,
  output fsc_pkg::fsc_word_t gain_active,
  output logic blank_frame,
  // Write classification
  output logic static_wr_running,
  output logic artifact_wr_running
);

  // Written copies of every register
  fsc_pkg::fsc_word_t regs [`FSC_NUM_REGS];

  // Write path
  logic wr_ok;
  logic running;
  logic switch_wr;
  fsc_pkg::fsc_word_t mode_w;
  fsc_pkg::fsc_word_t sync_w;
  fsc_pkg::fsc_wr_class_t wr_class;

  // Address group hits of the offered write
  logic hit_static;
  logic hit_mode_static;
  logic hit_black;
  logic hit_black_cfg;
  logic hit_sync;
  logic hit_sync_bit;
  logic hit_test;

  // Frame-start load strobes per freeze group
  logic load_roi;
  logic load_exp;
  logic load_gain;

  // Frame-synchronised copies
  logic switch_pending;
  logic sub_active;
  logic bin_active;
  logic [31:0] wen_active;
  logic [47:0] exp_written;
  logic [47:0] exp_stage;
  logic [47:0] exp_active;
  logic exp_fast;
  fsc_pkg::fsc_word_t gain_stage;
  fsc_pkg::fsc_word_t gain_act;

  // Read path
  fsc_pkg::fsc_word_t status_w;
  fsc_pkg::fsc_word_t rd_word;

  assign mode_w = regs[`FSC_A_MODE];
  assign sync_w = regs[`FSC_A_SYNC];
  assign running = mode_w[`FSC_B_SEQ_EN];
  assign wr_ok = ce && reg_wr && (reg_addr != `FSC_A_STATUS);
  assign exp_written = {regs[`FSC_A_EXP2],
                        regs[`FSC_A_EXP1],
                        regs[`FSC_A_EXP0]};

  // Window switch detection
  assign switch_wr = wr_ok && ((reg_addr == `FSC_A_WEN_LO) ||
                     (reg_addr == `FSC_A_WEN_HI));

  // Triggered master with exposure sync mode skips the extra frame
  assign exp_fast = mode_w[`FSC_B_TRIG] && !mode_w[`FSC_B_SLAVE] &&
                    sync_w[`FSC_B_EXP_SYNC];

  // A cleared sync bit freezes the active copy of its group
  assign load_roi = ce && frame_start &&
                    sync_w[`FSC_B_SY_ROI];
  assign load_exp = ce && frame_start &&
                    sync_w[`FSC_B_SY_EXP];
  assign load_gain = ce && frame_start &&
                     sync_w[`FSC_B_SY_GAIN];

  // Static group: clock, core, front end, output, bias
  assign hit_static = (reg_addr == `FSC_A_CLKGEN) ||
                      (reg_addr == `FSC_A_CORE) ||
                      (reg_addr == `FSC_A_AFE) ||
                      (reg_addr == `FSC_A_LVDS) ||
                      ((reg_addr >= `FSC_A_BIAS_LO) &&
                       (reg_addr <= `FSC_A_BIAS_HI));

  // Flipping trigger or slave selection is a static change
  assign hit_mode_static = (reg_addr == `FSC_A_MODE) &&
                           ((reg_wdata[`FSC_B_TRIG] !=
                             mode_w[`FSC_B_TRIG]) ||
                            (reg_wdata[`FSC_B_SLAVE] !=
                             mode_w[`FSC_B_SLAVE]));

  // Artifact groups: black level, sync codes, test pattern
  assign hit_black = (reg_addr >= `FSC_A_BLACK_LO) &&
                     (reg_addr <= `FSC_A_BLACK_HI);
  assign hit_black_cfg = (reg_addr == `FSC_A_BLK_CFG) &&
                         (reg_wdata[`FSC_B_BLK_CFG_HI:`FSC_B_BLK_CFG_LO] !=
                          regs[`FSC_A_BLK_CFG][`FSC_B_BLK_CFG_HI:
                                               `FSC_B_BLK_CFG_LO]);
  assign hit_sync = (reg_addr >= `FSC_A_SYNCC_LO) &&
                    (reg_addr <= `FSC_A_SYNCC_HI);
  assign hit_sync_bit = (reg_addr == `FSC_A_BLACK_HI) &&
                        (reg_wdata[`FSC_B_SYNCC] !=
                         regs[`FSC_A_BLACK_HI][`FSC_B_SYNCC]);
  assign hit_test = (reg_addr >= `FSC_A_TEST_LO) &&
                    (reg_addr <= `FSC_A_TEST_HI);

  // Write classification by address group
  always_comb begin
    wr_class = fsc_pkg::FSC_WR_PLAIN;
    if (hit_static || hit_mode_static) begin
      wr_class = fsc_pkg::FSC_WR_STATIC;
    end
    else if (hit_black || hit_black_cfg || hit_sync || hit_sync_bit ||
             hit_test) begin
      wr_class = fsc_pkg::FSC_WR_ARTIFACT;
    end
  end

  // Register store, one word per address, open in every sequencer state
  for (genvar g = 0; g < `FSC_NUM_REGS; g++) begin : g_word
    localparam logic [8:0] word_addr = 9'(g);
    localparam fsc_pkg::fsc_word_t rst_val =
      (word_addr == `FSC_A_MODE) ? `FSC_RST_MODE :
      (word_addr == `FSC_A_WEN_LO) ? `FSC_RST_WEN_LO :
      (word_addr == `FSC_A_WEN_HI) ? `FSC_RST_WEN_HI :
      (word_addr == `FSC_A_SYNC) ? `FSC_RST_SYNC :
      (word_addr == `FSC_A_WIN_LO) ? `FSC_RST_WIN0_W0 :
      (word_addr == `FSC_A_WIN_LO + 9'h001) ? `FSC_RST_WIN0_W1 :
      (word_addr == `FSC_A_WIN_LO + 9'h002) ? `FSC_RST_WIN0_W2 :
      16'h0000;
    fsc_pkg::fsc_word_t word;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        word <= rst_val;
      end
      else if (wr_ok && (reg_addr == word_addr)) begin
        // Static writes land even while running
        word <= reg_wdata;
      end
    end
    assign regs[g] = word;
  end

  // Status word
  assign status_w = {12'h000,
                     switch_pending,
                     blank_frame,
                     bin_active,
                     sub_active};

  // Read source: live status or the written copy
  always_comb begin
    rd_word = regs[reg_addr];
    if (reg_addr == `FSC_A_STATUS) begin
      rd_word = status_w;
    end
  end

  // Read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end
    else if (ce && reg_rd) begin
      reg_rdata <= rd_word;
    end
  end

  // Static write while running, one-cycle pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      static_wr_running <= 1'b0;
    end
    else if (ce) begin
      static_wr_running <= wr_ok && running &&
                           (wr_class == fsc_pkg::FSC_WR_STATIC);
    end
  end

  // Artifact-prone write while running, one-cycle pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      artifact_wr_running <= 1'b0;
    end
    else if (ce) begin
      artifact_wr_running <= wr_ok && running &&
                             (wr_class == fsc_pkg::FSC_WR_ARTIFACT);
    end
  end

  // Pending window switch; a new write wins over the frame clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_pending <= 1'b0;
    end
    else if (ce) begin
      if (switch_wr) begin
        switch_pending <= 1'b1;
      end
      else if (frame_start && sync_w[`FSC_B_SY_ROI]) begin
        switch_pending <= 1'b0;
      end
    end
  end

  // Blanked frame with training output after a switch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blank_frame <= 1'b0;
    end
    else if (ce && frame_start) begin
      // Geometry writes never reach here
      blank_frame <= switch_pending && running &&
                     sync_w[`FSC_B_SY_ROI];
    end
  end

  // Active window set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wen_active <= {`FSC_RST_WEN_HI, `FSC_RST_WEN_LO};
    end
    else if (load_roi) begin
      // Frozen group keeps its old values
      wen_active <= {regs[`FSC_A_WEN_HI],
                     regs[`FSC_A_WEN_LO]};
    end
  end

  // Readout mode set, same freeze group as the windows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_active <= 1'b0;
      bin_active <= 1'b0;
    end
    else if (load_roi) begin
      sub_active <= mode_w[`FSC_B_SUB];
      bin_active <= mode_w[`FSC_B_BIN];
    end
  end

  // Exposure staged copy, one frame behind the written words
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_stage <= 48'h000000000000;
    end
    else if (load_exp) begin
      exp_stage <= exp_written;
    end
  end

  // Exposure active copy, from the stage unless in fast sync mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_active <= 48'h000000000000;
    end
    else if (load_exp) begin
      if (exp_fast) begin
        exp_active <= exp_written;
      end
      else begin
        exp_active <= exp_stage;
      end
    end
  end

  // Gain staged copy, for the extra frame of latency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_stage <= 16'h0000;
    end
    else if (load_gain) begin
      gain_stage <= regs[`FSC_A_GAIN];
    end
  end

  // Gain: next frame, or one more to line up with exposure
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_act <= 16'h0000;
    end
    else if (load_gain) begin
      if (regs[`FSC_A_GAIN][`FSC_B_GAIN_LAT]) begin
        gain_act <= gain_stage;
      end
      else begin
        gain_act <= regs[`FSC_A_GAIN];
      end
    end
  end

  // Immediate static selections
  assign seq_enable = running;
  assign triggered_mode = mode_w[`FSC_B_TRIG];
  assign slave_mode = mode_w[`FSC_B_SLAVE];

  // Frame-synchronised active values
  assign subsample_en = sub_active;
  assign binning_en = bin_active;
  assign window_enable = wen_active;
  assign exposure_active = exp_active;
  assign gain_active = gain_act;

endmodule // fsc_config_update

// ---- hw/fsc_consts.svh ----
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// Register space
`define FSC_NUM_REGS 512
`define FSC_A_CLKGEN 9'h020
`define FSC_A_CORE 9'h028
`define FSC_A_AFE 9'h030
`define FSC_A_BIAS_LO 9'h040
`define FSC_A_BIAS_HI 9'h047
`define FSC_A_LVDS 9'h070
`define FSC_A_SYNCC_LO 9'h074
`define FSC_A_SYNCC_HI 9'h07e
`define FSC_A_BLACK_LO 9'h080
`define FSC_A_BLACK_HI 9'h081
`define FSC_A_TEST_LO 9'h090
`define FSC_A_TEST_HI 9'h096
`define FSC_A_MODE 9'h0c0
`define FSC_A_WEN_LO 9'h0c3
`define FSC_A_WEN_HI 9'h0c4
`define FSC_A_BLK_CFG 9'h0c5
`define FSC_A_EXP0 9'h0c7
`define FSC_A_EXP1 9'h0c8
`define FSC_A_EXP2 9'h0c9
`define FSC_A_GAIN 9'h0cc
`define FSC_A_SYNC 9'h0ce
`define FSC_A_STATUS 9'h0ff
`define FSC_A_WIN_LO 9'h100
`define FSC_A_WIN_HI 9'h15f

// Field positions
`define FSC_B_SEQ_EN 0
`define FSC_B_TRIG 4
`define FSC_B_SLAVE 5
`define FSC_B_SUB 7
`define FSC_B_BIN 8
`define FSC_B_GAIN_LAT 13
`define FSC_B_SYNCC 13
`define FSC_B_BLK_CFG_LO 8
`define FSC_B_BLK_CFG_HI 12
`define FSC_B_SY_BLACK 0
`define FSC_B_SY_EXP 1
`define FSC_B_SY_GAIN 2
`define FSC_B_SY_ROI 3
`define FSC_B_EXP_SYNC 8

// Reset values
`define FSC_RST_MODE 16'h0000
`define FSC_RST_WEN_LO 16'h0001
`define FSC_RST_WEN_HI 16'h0000
`define FSC_RST_SYNC 16'h000f
`define FSC_RST_WIN0_W0 16'h4f00
`define FSC_RST_WIN0_W1 16'h0000
`define FSC_RST_WIN0_W2 16'h13ff

`endif

// ---- hw/fsc_pkg.sv ----
package fsc_pkg;
  typedef logic [15:0] fsc_word_t;
  typedef logic [8:0] fsc_addr_t;
  typedef enum logic [1:0] {
    FSC_WR_PLAIN,
    FSC_WR_STATIC,
    FSC_WR_ARTIFACT
  } fsc_wr_class_t;
endpackage

// ---- tb/fsc_config_update_monitor.sv ----
`timescale 1ns/100ps
module fsc_config_update_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic frame_start,
  // Outputs
  input wire logic seq_enable,
  input wire logic subsample_en,
  input wire logic binning_en,
  input wire logic [31:0] window_enable,
  input wire logic [47:0] exposure_active,
  input wire fsc_pkg::fsc_word_t gain_active,
  input wire logic blank_frame,
  input wire logic static_wr_running,
  input wire logic artifact_wr_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_sub_on_frame: assert property ($changed(subsample_en) |->
    $past(frame_start) && $past(ce)) else $error("sub off frame");
  a_bin_on_frame: assert property ($changed(binning_en) |->
    $past(frame_start) && $past(ce)) else $error("bin off frame");
  a_win_on_frame: assert property ($changed(window_enable) |->
    $past(frame_start) && $past(ce)) else $error("window off frame");
  a_exp_on_frame: assert property ($changed(exposure_active) |->
    $past(frame_start) && $past(ce)) else $error("exposure off frame");
  a_gain_on_frame: assert property ($changed(gain_active) |->
    $past(frame_start) && $past(ce)) else $error("gain off frame");
  a_blank_when_run: assert property ($rose(blank_frame) |->
    $past(frame_start) && $past(seq_enable)) else $error("blank cause");
  a_static_flag: assert property (static_wr_running |->
    $past(reg_wr) && $past(seq_enable)) else $error("static flag");
  a_artifact_flag: assert property (artifact_wr_running |->
    $past(reg_wr) && $past(seq_enable)) else $error("artifact flag");
endmodule // fsc_config_update_monitor
bind fsc_config_update fsc_config_update_monitor i_mon (
  .clk, .arst_n, .ce, .reg_wr, .frame_start, .seq_enable, .subsample_en,
  .binning_en, .window_enable, .exposure_active, .gain_active,
  .blank_frame, .static_wr_running, .artifact_wr_running
);

// ---- tb/fsc_host_model.sv ----
`timescale 1ns/100ps
module fsc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output fsc_pkg::fsc_addr_t reg_addr = 9'h000,
  output fsc_pkg::fsc_word_t reg_wdata = 16'h0000,
  input wire fsc_pkg::fsc_word_t reg_rdata
);
  // One-cycle write to whatever address is given, then inverted address and data
  task automatic wr(input fsc_pkg::fsc_addr_t a, fsc_pkg::fsc_word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input fsc_pkg::fsc_addr_t a,
                    output fsc_pkg::fsc_word_t d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // fsc_host_model

// ---- tb/tb_fsc_config_update.sv ----
`timescale 1ns/100ps
module tb_fsc_config_update;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic frame_start = 1'b0;
  logic reg_wr, reg_rd, seq_enable, triggered_mode, slave_mode;
  logic subsample_en, binning_en, blank_frame, static_wr_running;
  logic artifact_wr_running;
  fsc_pkg::fsc_addr_t reg_addr;
  fsc_pkg::fsc_word_t reg_wdata, reg_rdata, gain_active, v;
  logic [31:0] window_enable;
  logic [47:0] exposure_active;
  int errors = 0;
  int checks_done = 0;
  fsc_pkg::fsc_addr_t ra[6] = '{9'h0c0, 9'h0c3, 9'h0c4, 9'h0ce, 9'h100,
    9'h102};
  fsc_pkg::fsc_word_t rv[6] = '{16'h0000, 16'h0001, 16'h0000, 16'h000f,
    16'h4f00, 16'h13ff};
  fsc_pkg::fsc_addr_t aa[3] = '{9'h080, 9'h074, 9'h090};
  always #12.5 clk = ~clk;
  fsc_config_update i_dut (
    .clk, .arst_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .frame_start, .seq_enable, .triggered_mode, .slave_mode,
    .subsample_en, .binning_en, .window_enable, .exposure_active,
    .gain_active, .blank_frame, .static_wr_running, .artifact_wr_running
  );
  fsc_host_model i_host (
    .clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
  );
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic frame();
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i]) begin
      i_host.rd(ra[i], v);
      chk(v, rv[i]);
    end
    chk(window_enable, 48'h1);
    i_host.wr(9'h020, 16'h2005);
    chk(static_wr_running, 1'b0);
    i_host.wr(9'h0c0, 16'h01b0);
    chk({triggered_mode, slave_mode}, 2'b11);
    chk({subsample_en, binning_en}, 2'b00);
    frame();
    chk({subsample_en, binning_en}, 2'b11);
    i_host.wr(9'h0c0, 16'h000d);
    chk({seq_enable, triggered_mode}, 2'b10);
    i_host.wr(9'h020, 16'h2004);
    chk(static_wr_running, 1'b1);
    foreach (aa[i]) begin
      i_host.wr(aa[i], 16'h0001);
      chk(artifact_wr_running, 1'b1);
    end
    i_host.wr(9'h0c3, 16'h0003);
    i_host.wr(9'h101, 16'h0000);
    chk(window_enable, 48'h1);
    frame();
    chk({blank_frame, window_enable}, 48'h1_0000_0003);
    chk({subsample_en, binning_en}, 2'b00);
    i_host.rd(9'h0ff, v);
    chk(v, 16'h0004);
    i_host.rd(9'h0c3, v);
    chk(v, 16'h0003);
    i_host.wr(9'h100, 16'h2700);
    frame();
    chk(blank_frame, 1'b0);
    i_host.wr(9'h0c7, 16'h0123);
    frame();
    chk(exposure_active, 48'h0);
    frame();
    chk(exposure_active, 48'h123);
    i_host.wr(9'h0ce, 16'h010f);
    i_host.wr(9'h0c0, 16'h001d);
    i_host.wr(9'h0c8, 16'h0001);
    frame();
    chk(exposure_active, 48'h1_0123);
    i_host.wr(9'h0cc, 16'h2066);
    frame();
    chk(gain_active, 48'h0);
    frame();
    chk(gain_active, 48'h2066);
    i_host.wr(9'h0ce, 16'h0000);
    i_host.wr(9'h0cc, 16'h0077);
    frame();
    chk(gain_active, 48'h2066);
    i_host.wr(9'h0ce, 16'h000f);
    @(posedge clk) ce <= 1'b0;
    frame();
    chk(gain_active, 48'h2066);
    @(posedge clk) ce <= 1'b1;
    frame();
    chk(gain_active, 48'h77);
    i_host.wr(9'h0c0, 16'h000c);
    chk(seq_enable, 1'b0);
    print_verdict();
  end
endmodule // tb_fsc_config_update
